// file: timer_sync_pkg.sv
// constants for the synchronised timer with buffered capture/compare
// assumes a 32-bit AXI4-Lite register bus, one word per register
package timer_sync_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_EVGEN   = 8'h08;
    localparam logic [7:0] OFS_COUNT   = 8'h0C;
    localparam logic [7:0] OFS_PRESC   = 8'h10;
    localparam logic [7:0] OFS_RELOAD  = 8'h14;
    localparam logic [7:0] OFS_CCV_HI  = 8'h18;
    localparam logic [7:0] OFS_CCV_LO  = 8'h1C;
    // ------------------------------------------------------------------
    // control, status and event field positions
    // ------------------------------------------------------------------
    localparam int CTL_RUN   = 0;
    localparam int CTL_ALIGN = 1;
    localparam int CTL_MMS   = 4;
    localparam int CTL_SMS   = 8;
    localparam int CTL_TS    = 12;
    localparam int CTL_CCS   = 16;
    localparam int CTL_POL   = 18;
    localparam int CTL_FLT   = 20;
    localparam int CTL_CPSC  = 24;
    localparam int ST_TRIG   = 0;
    localparam int EV_UG     = 0;
    // ------------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------------
    localparam logic [2:0] MMS_RESET  = 3'h0;
    localparam logic [2:0] MMS_ENABLE = 3'h1;
    localparam logic [2:0] MMS_UPDATE = 3'h2;
    localparam logic [2:0] MMS_CMP1   = 3'h4;
    localparam logic [2:0] TS_MASTER  = 3'h1;
    localparam logic [2:0] TS_CH1     = 3'h4;
    localparam logic [2:0] SMS_GATED  = 3'h5;
    localparam logic [2:0] SMS_TRIG   = 3'h6;
    localparam logic [1:0] CCS_OUTPUT = 2'h0;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLV   = 2'h2;
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_RELOAD = 16'hFFFF;
    localparam logic [15:0] RST_ZERO16 = 16'h0000;
endpackage : timer_sync_pkg

// file: timer_sync.sv
// synchronisable 16-bit timer: master trigger out, slave gate/start,
// channel 1 input stage and byte-wise buffered capture/compare value
// assumes trigger and channel pin arrive asynchronously; AXI4-Lite master
//
// Functional notes
// - master select 100 outputs compare reference
// - master select 010 outputs update event
// - master select 001 outputs counter enable
// - trigger select 001 takes master trigger
// - trigger select 100 takes channel 1 pin
// - gated mode counts only while trigger high
// - gating acts on counter enable only
// - trigger mode sets run bit in hardware
// - triggered counter resumes from current value
// - align bit delays own counter enable
// - trigger start sets trigger flag
// - update generate reinitialises counter and prescaler
// - counter accepts any software value
// - output channel value freely read and written
// - software accesses reach preload copy only
// - capture fills shadow, then unfrozen preload
// - compare loads shadow from preload, compares
// - read sequence freezes preload until low read
// - lone low read returns live value
// - high byte write blocks shadow update
// - input sampled, filtered, edge detected, prescaled
// - gated mode flags every start and stop
// - master select 1xx outputs compare reference
`default_nettype none
module timer_sync (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // axi4-lite write
    input  wire logic [7:0]  awaddr_in,
    input  wire logic        awvalid_in,
    output logic             awready_out,
    input  wire logic [31:0] wdata_in,
    input  wire logic [3:0]  wstrb_in,
    input  wire logic        wvalid_in,
    output logic             wready_out,
    output logic [1:0]       bresp_out,
    output logic             bvalid_out,
    input  wire logic        bready_in,
    // axi4-lite read
    input  wire logic [7:0]  araddr_in,
    input  wire logic        arvalid_in,
    output logic             arready_out,
    output logic [31:0]      rdata_out,
    output logic [1:0]       rresp_out,
    output logic             rvalid_out,
    input  wire logic        rready_in,
    // link to other timers and pin
    input  wire logic        master_trigger_in,
    input  wire logic        channel1_input_pin_in,
    output logic             trigger_out,
    output logic             compare1_reference_out,
    output logic             trigger_flag_out
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        awr, wr, bv, arr, rv;
        logic [1:0]  bresp, rresp;
        logic [31:0] rdata;
        logic        counter_run, master_slave_align;
        logic [2:0]  master_trigger_select, slave_mode_select;
        logic [2:0]  trigger_source_select;
        logic [1:0]  channel_direction_select, cap_psc;
        logic        polarity;
        logic [3:0]  filter_len, filt_cnt;
        logic        trigger_flag;
        logic [15:0] cnt, psc_cnt, presc, reload, preload, shadow;
        logic        rd_frozen, wr_block;
        logic [1:0]  mt_sync, pin_sync;
        logic        filtered_channel_input, edge_prev, trig_prev, gate_prev;
        logic [2:0]  cap_cnt;
        logic        cen_dly, update_event, trig, cmp_ref;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] d,
                                            input logic [3:0]  st);
        merge16 = {st[1] ? d[15:8] : old_v[15:8], st[0] ? d[7:0] : old_v[7:0]};
    endfunction : merge16

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= timer_sync_pkg::OFS_CCV_LO);
    endfunction : mapped

    logic        edge_detected_channel_input;
    logic        trig_sel;
    logic        counter_enable_signal;
    logic        prescaler_clock;
    logic        capture_prescaled_command;
    logic        do_wr;
    logic        do_rd;
    logic [2:0]  cap_div;
    logic        flag_set;

    always_comb begin
        s_nxt = s_r;
        flag_set = 1'b0;
        // --------------------------------------------------------------
        // input stage
        // --------------------------------------------------------------
        s_nxt.pin_sync = {s_r.pin_sync[0], channel1_input_pin_in};
        s_nxt.mt_sync  = {s_r.mt_sync[0], master_trigger_in};
        if (s_r.pin_sync[1] == s_r.filtered_channel_input) begin
            s_nxt.filt_cnt = 4'h0;
        end else if (s_r.filt_cnt >= s_r.filter_len) begin
            s_nxt.filtered_channel_input = s_r.pin_sync[1];
            s_nxt.filt_cnt = 4'h0;
        end else begin
            s_nxt.filt_cnt = s_r.filt_cnt + 4'h1;
        end
        // polarity select before edge detection
        edge_detected_channel_input = s_r.filtered_channel_input ^ s_r.polarity;
        s_nxt.edge_prev = edge_detected_channel_input;
        cap_div = 3'h0;
        case (s_r.cap_psc)
            2'h1:    cap_div = 3'h1;
            2'h2:    cap_div = 3'h3;
            2'h3:    cap_div = 3'h7;
            default: cap_div = 3'h0;
        endcase
        capture_prescaled_command = 1'b0;
        if (edge_detected_channel_input && !s_r.edge_prev) begin
            if (s_r.cap_cnt >= cap_div) begin
                capture_prescaled_command = 1'b1;
                s_nxt.cap_cnt = 3'h0;
            end else begin
                s_nxt.cap_cnt = s_r.cap_cnt + 3'h1;
            end
        end
        // --------------------------------------------------------------
        // slave trigger selection and control
        // --------------------------------------------------------------
        case (s_r.trigger_source_select)
            timer_sync_pkg::TS_MASTER: trig_sel = s_r.mt_sync[1];
            timer_sync_pkg::TS_CH1:    trig_sel = edge_detected_channel_input;
            default:                   trig_sel = 1'b0;
        endcase
        s_nxt.trig_prev = trig_sel;
        if (s_r.slave_mode_select == timer_sync_pkg::SMS_TRIG
            && trig_sel && !s_r.trig_prev) begin
            s_nxt.counter_run  = 1'b1;
            s_nxt.trigger_flag = 1'b1;
            flag_set = 1'b1;
        end
        // gating touches only the enable, never the count itself
        counter_enable_signal = s_r.counter_run
            && (s_r.slave_mode_select != timer_sync_pkg::SMS_GATED || trig_sel);
        s_nxt.gate_prev = counter_enable_signal;
        if (s_r.slave_mode_select == timer_sync_pkg::SMS_GATED
            && counter_enable_signal != s_r.gate_prev) begin
            s_nxt.trigger_flag = 1'b1;
            flag_set = 1'b1;
        end
        s_nxt.cen_dly = counter_enable_signal;
        // --------------------------------------------------------------
        // prescaler and counter
        // --------------------------------------------------------------
        prescaler_clock = 1'b0;
        s_nxt.update_event = 1'b0;
        if (s_r.master_slave_align ? s_r.cen_dly : counter_enable_signal) begin
            if (s_r.psc_cnt >= s_r.presc) begin
                s_nxt.psc_cnt = timer_sync_pkg::RST_ZERO16;
                prescaler_clock = 1'b1;
            end else begin
                s_nxt.psc_cnt = s_r.psc_cnt + 16'h0001;
            end
        end
        if (prescaler_clock) begin
            if (s_r.cnt >= s_r.reload) begin
                s_nxt.cnt = timer_sync_pkg::RST_ZERO16;
                s_nxt.update_event = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt + 16'h0001;
            end
        end
        // --------------------------------------------------------------
        // capture/compare buffering
        // --------------------------------------------------------------
        if (s_r.channel_direction_select != timer_sync_pkg::CCS_OUTPUT) begin
            if (capture_prescaled_command) begin
                s_nxt.shadow = s_r.cnt;
                if (!s_r.rd_frozen) begin
                    s_nxt.preload = s_r.cnt;
                end
            end
        end else if (!s_r.wr_block) begin
            s_nxt.shadow = s_r.preload;
        end
        s_nxt.cmp_ref = s_r.cnt < s_r.shadow;
        // --------------------------------------------------------------
        // axi4-lite slave, one write and one read at a time
        // --------------------------------------------------------------
        do_wr = s_r.awr && s_r.wr;
        do_rd = s_r.arr;
        s_nxt.awr = 1'b0;
        s_nxt.wr  = 1'b0;
        s_nxt.arr = 1'b0;
        if (awvalid_in && wvalid_in && !s_r.awr && !s_r.bv) begin
            s_nxt.awr = 1'b1;
            s_nxt.wr  = 1'b1;
        end
        if (s_r.bv && bready_in) begin
            s_nxt.bv = 1'b0;
        end
        if (do_wr) begin
            s_nxt.bv    = 1'b1;
            s_nxt.bresp = mapped(awaddr_in) ? timer_sync_pkg::RESP_OKAY
                                            : timer_sync_pkg::RESP_SLV;
            case (awaddr_in)
                timer_sync_pkg::OFS_CTRL: if (wstrb_in == 4'hF) begin
                    s_nxt.counter_run              = wdata_in[timer_sync_pkg::CTL_RUN];
                    s_nxt.master_slave_align       = wdata_in[timer_sync_pkg::CTL_ALIGN];
                    s_nxt.master_trigger_select    = wdata_in[timer_sync_pkg::CTL_MMS +: 3];
                    s_nxt.slave_mode_select        = wdata_in[timer_sync_pkg::CTL_SMS +: 3];
                    s_nxt.trigger_source_select    = wdata_in[timer_sync_pkg::CTL_TS +: 3];
                    s_nxt.channel_direction_select = wdata_in[timer_sync_pkg::CTL_CCS +: 2];
                    s_nxt.polarity                 = wdata_in[timer_sync_pkg::CTL_POL];
                    s_nxt.filter_len               = wdata_in[timer_sync_pkg::CTL_FLT +: 4];
                    s_nxt.cap_psc                  = wdata_in[timer_sync_pkg::CTL_CPSC +: 2];
                end
                timer_sync_pkg::OFS_STATUS:
                    // a trigger in the same cycle keeps the flag set
                    if (wstrb_in[0] && wdata_in[timer_sync_pkg::ST_TRIG]
                        && !flag_set) begin
                        s_nxt.trigger_flag = 1'b0;
                    end
                timer_sync_pkg::OFS_EVGEN:
                    if (wstrb_in[0] && wdata_in[timer_sync_pkg::EV_UG]) begin
                        s_nxt.cnt          = timer_sync_pkg::RST_ZERO16;
                        s_nxt.psc_cnt      = timer_sync_pkg::RST_ZERO16;
                        s_nxt.update_event = 1'b1;
                    end
                timer_sync_pkg::OFS_COUNT:
                    s_nxt.cnt = merge16(s_r.cnt, wdata_in, wstrb_in);
                timer_sync_pkg::OFS_PRESC:
                    s_nxt.presc = merge16(s_r.presc, wdata_in, wstrb_in);
                timer_sync_pkg::OFS_RELOAD:
                    s_nxt.reload = merge16(s_r.reload, wdata_in, wstrb_in);
                timer_sync_pkg::OFS_CCV_HI:
                    if (wstrb_in[0] && s_r.channel_direction_select
                        == timer_sync_pkg::CCS_OUTPUT) begin
                        s_nxt.preload[15:8] = wdata_in[7:0];
                        s_nxt.wr_block      = 1'b1;
                    end
                timer_sync_pkg::OFS_CCV_LO:
                    if (wstrb_in[0] && s_r.channel_direction_select
                        == timer_sync_pkg::CCS_OUTPUT) begin
                        s_nxt.preload[7:0] = wdata_in[7:0];
                        s_nxt.wr_block     = 1'b0;
                    end
                default: ;
            endcase
        end
        if (s_r.rv && rready_in) begin
            s_nxt.rv = 1'b0;
        end
        if (arvalid_in && !s_r.arr && !s_r.rv) begin
            s_nxt.arr = 1'b1;
        end
        if (do_rd) begin
            s_nxt.rv    = 1'b1;
            s_nxt.rdata = 32'h0000_0000;
            s_nxt.rresp = mapped(araddr_in) ? timer_sync_pkg::RESP_OKAY
                                            : timer_sync_pkg::RESP_SLV;
            case (araddr_in)
                timer_sync_pkg::OFS_CTRL: begin
                    s_nxt.rdata[timer_sync_pkg::CTL_RUN]     = s_r.counter_run;
                    s_nxt.rdata[timer_sync_pkg::CTL_ALIGN]   = s_r.master_slave_align;
                    s_nxt.rdata[timer_sync_pkg::CTL_MMS +: 3] = s_r.master_trigger_select;
                    s_nxt.rdata[timer_sync_pkg::CTL_SMS +: 3] = s_r.slave_mode_select;
                    s_nxt.rdata[timer_sync_pkg::CTL_TS +: 3]  = s_r.trigger_source_select;
                    s_nxt.rdata[timer_sync_pkg::CTL_CCS +: 2] = s_r.channel_direction_select;
                    s_nxt.rdata[timer_sync_pkg::CTL_POL]     = s_r.polarity;
                    s_nxt.rdata[timer_sync_pkg::CTL_FLT +: 4] = s_r.filter_len;
                    s_nxt.rdata[timer_sync_pkg::CTL_CPSC +: 2] = s_r.cap_psc;
                end
                timer_sync_pkg::OFS_STATUS:
                    s_nxt.rdata[timer_sync_pkg::ST_TRIG] = s_r.trigger_flag;
                timer_sync_pkg::OFS_COUNT:  s_nxt.rdata[15:0] = s_r.cnt;
                timer_sync_pkg::OFS_PRESC:  s_nxt.rdata[15:0] = s_r.presc;
                timer_sync_pkg::OFS_RELOAD: s_nxt.rdata[15:0] = s_r.reload;
                timer_sync_pkg::OFS_CCV_HI: begin
                    s_nxt.rdata[7:0] = s_r.preload[15:8];
                    if (s_r.channel_direction_select != timer_sync_pkg::CCS_OUTPUT) begin
                        s_nxt.rd_frozen = 1'b1;
                    end
                end
                timer_sync_pkg::OFS_CCV_LO: begin
                    // unfrozen preload follows captures, so a lone read is live
                    s_nxt.rdata[7:0] = s_r.preload[7:0];
                    s_nxt.rd_frozen  = 1'b0;
                end
                default: ;
            endcase
        end
        // --------------------------------------------------------------
        // master trigger output
        // --------------------------------------------------------------
        case (s_r.master_trigger_select)
            timer_sync_pkg::MMS_RESET:  s_nxt.trig = s_nxt.update_event && do_wr;
            timer_sync_pkg::MMS_ENABLE: s_nxt.trig = counter_enable_signal;
            timer_sync_pkg::MMS_UPDATE: s_nxt.trig = s_nxt.update_event;
            default:                    s_nxt.trig = s_nxt.cmp_ref;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r        <= '0;
            s_r.reload <= timer_sync_pkg::RST_RELOAD;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign awready_out            = s_r.awr;
    assign wready_out             = s_r.wr;
    assign bvalid_out             = s_r.bv;
    assign bresp_out              = s_r.bresp;
    assign arready_out            = s_r.arr;
    assign rvalid_out             = s_r.rv;
    assign rdata_out              = s_r.rdata;
    assign rresp_out              = s_r.rresp;
    assign trigger_out            = s_r.trig;
    assign compare1_reference_out = s_r.cmp_ref;
    assign trigger_flag_out       = s_r.trigger_flag;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_REF_OUT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_r.master_trigger_select == timer_sync_pkg::MMS_CMP1
        && $stable(s_r.master_trigger_select) |=> trigger_out == $past(s_r.cnt < s_r.shadow))
        else $error("trigger does not follow compare reference");
    AST_UEV_PULSE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_r.master_trigger_select == timer_sync_pkg::MMS_UPDATE && trigger_out
        && s_r.presc != 16'h0000 |=> !trigger_out)
        else $error("update trigger wider than one cycle");
    AST_ENABLE_OUT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_r.master_trigger_select == timer_sync_pkg::MMS_ENABLE
        |=> trigger_out == $past(counter_enable_signal))
        else $error("trigger does not show counter enable");
    AST_GATE_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !s_r.master_slave_align && !counter_enable_signal && !do_wr |=> $stable(s_r.cnt))
        else $error("counter moved while gated off");
    AST_TRIG_START: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_r.slave_mode_select == timer_sync_pkg::SMS_TRIG && trig_sel && !s_r.trig_prev
        && !do_wr |=> s_r.counter_run && s_r.trigger_flag)
        else $error("trigger did not start counter");
    AST_FREEZE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_r.rd_frozen && !do_rd && !do_wr |=> $stable(s_r.preload))
        else $error("frozen preload changed");
    AST_WR_BLOCK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_r.wr_block && s_r.channel_direction_select == timer_sync_pkg::CCS_OUTPUT
        |=> $stable(s_r.shadow))
        else $error("shadow updated during byte write");
    AST_UG: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        do_wr && awaddr_in == timer_sync_pkg::OFS_EVGEN && wstrb_in[0] && wdata_in[0]
        |=> s_r.cnt == 16'h0000 && s_r.psc_cnt == 16'h0000)
        else $error("update generate did not clear counter");
    AST_ALIGN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_r.master_slave_align && !$past(counter_enable_signal) && !do_wr
        && $past(!do_wr) |=> $stable(s_r.cnt))
        else $error("aligned enable not delayed");
endmodule : timer_sync
`default_nettype wire

// file: partner_timer.sv
// partner master timer: its enable goes out as trigger, one cycle late; bench clock
`default_nettype none
module partner_timer (input wire logic clk_in, input wire logic run_in, output logic trigger_out);
    timeunit 1ns / 1ps;
    always_ff @(posedge clk_in) trigger_out <= run_in;
endmodule : partner_timer
`default_nettype wire

// file: timer_sync_tb.sv
// bench for timer_sync: bus tasks, partner master timer and channel pin drive
// assumes AXI4-Lite answers well inside the watchdog span; the ready line of the last call stays up between calls
`default_nettype none
module timer_sync_tb;
    timeunit 1ns / 1ps;
    logic        clk_in = 1'h0, rst_n_in = 1'h0, run = 1'h0, awvalid_in = 1'h0, wvalid_in = 1'h0;
    logic        bready_in = 1'h0, arvalid_in = 1'h0, rready_in = 1'h0, channel1_input_pin_in = 1'h0;
    logic        awready_out, wready_out, bvalid_out, arready_out, rvalid_out, trigger_out;
    logic        master_trigger_in, compare1_reference_out, trigger_flag_out;
    logic [7:0]  awaddr_in = 8'h00, araddr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0, rdata_out, rdv;
    logic [3:0]  wstrb_in = 4'hF;
    logic [1:0]  bresp_out, rresp_out, rs;
    int          fails, n_compared;
    initial forever #5 clk_in = ~clk_in;
    timer_sync timer_sync_i (.*);
    partner_timer partner_timer_i (.clk_in, .run_in(run), .trigger_out(master_trigger_in));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        fails += int'(s !== e);
        if (s !== e) $display("BAD %s exp %h got %h", nm, e, s);
    endtask : chk
    // one write or one read; a named read is compared against d
    task bus(input string nm, input logic w, input logic [7:0] ad, input logic [31:0] d);
        {awaddr_in, araddr_in, wdata_in} <= {ad, ad, d};
        {awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} <= {w, w, w, !w, !w};
        do @(posedge clk_in); while ((w ? awready_out : arready_out) !== 1'h1);
        {awvalid_in, wvalid_in, arvalid_in} <= 3'h0;
        while ((w ? bvalid_out : rvalid_out) !== 1'h1) @(posedge clk_in);
        {rs, rdv} = {w ? bresp_out : rresp_out, rdata_out};
        if (nm != "") chk(nm, d, rdv);
    endtask : bus
    task conclude;
        $display("compared %0d, mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    task t_regs;
        bus("unmapped", 1'h0, 8'h20, 32'h0);
        chk("unmapped resp", 32'h2, 32'(rs));
        bus("", 1'h1, 8'h18, 32'h12);
        bus("", 1'h1, 8'h1C, 32'h34);
        bus("ccv hi", 1'h0, 8'h18, 32'h12);
        chk("ref", 32'h1, 32'(compare1_reference_out));
        $display("regs test done");
    endtask : t_regs
    task t_gate;
        bus("", 1'h1, 8'h00, 32'h1501);
        run <= 1'h1;
        repeat (20) @(posedge clk_in);
        bus("", 1'h0, 8'h0C, 32'h0);
        chk("gate run", 32'h1, 32'(rdv > 32'h8));
        chk("gate flag", 32'h1, 32'(trigger_flag_out));
        run <= 1'h0;
        repeat (8) @(posedge clk_in);
        bus("", 1'h0, 8'h0C, 32'h0);
        bus("gate hold", 1'h0, 8'h0C, rdv);
        bus("", 1'h1, 8'h08, 32'h1);
        bus("ug", 1'h0, 8'h0C, 32'h0);
        $display("gate test done");
    endtask : t_gate
    // flag is cleared after the mode change so only the pin edge can set it
    task t_trig;
        bus("", 1'h1, 8'h00, 32'h4612);
        bus("", 1'h1, 8'h0C, 32'hE7);
        bus("", 1'h1, 8'h04, 32'h1);
        channel1_input_pin_in <= 1'h1;
        repeat (8) @(posedge clk_in);
        bus("run set", 1'h0, 8'h00, 32'h4613);
        chk("trig out", 32'h1, 32'(trigger_out));
        chk("trig flag", 32'h1, 32'(trigger_flag_out));
        bus("", 1'h0, 8'h0C, 32'h0);
        chk("resume", 32'h1, 32'(rdv > 32'hE7 && rdv < 32'h120));
        $display("trig test done");
    endtask : t_trig
    // one rising edge on the channel pin, long enough to pass sync and filter
    task pulse_pin;
        channel1_input_pin_in <= 1'h0;
        repeat (6) @(posedge clk_in);
        channel1_input_pin_in <= 1'h1;
        repeat (6) @(posedge clk_in);
    endtask : pulse_pin
    // counter stopped so every capture takes a known value
    task t_capture;
        bus("", 1'h1, 8'h00, 32'h10000);
        bus("", 1'h1, 8'h0C, 32'h1234);
        pulse_pin();
        bus("cap hi", 1'h0, 8'h18, 32'h12);
        bus("", 1'h1, 8'h0C, 32'h5678);
        pulse_pin();
        bus("cap lo frozen", 1'h0, 8'h1C, 32'h34);
        pulse_pin();
        bus("cap lo live", 1'h0, 8'h1C, 32'h78);
        $display("capture test done");
    endtask : t_capture
    task t_master;
        int n;
        n = 0;
        bus("", 1'h1, 8'h14, 32'h3);
        bus("", 1'h1, 8'h00, 32'h21);
        repeat (40) begin
            @(posedge clk_in);
            n += int'(trigger_out === 1'h1);
        end
        chk("uev pulses", 32'hA, 32'(n));
        bus("", 1'h1, 8'h00, 32'h41);
        repeat (3) @(posedge clk_in);
        chk("ref trig", 32'(compare1_reference_out), 32'(trigger_out));
        $display("master test done");
    endtask : t_master
    initial begin
        #50us fails++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'h1;
        t_regs();
        t_gate();
        t_trig();
        t_capture();
        t_master();
        conclude();
    end
endmodule : timer_sync_tb
`default_nettype wire
